// ==== core/dsc_top.sv ====
// dsss scrambler, dibit encoder, descrambler, cca and demod loop
// Overview of operation
// - dibit 00,01,11,10 steps phase by 0, +90, 180, -90 degrees
// - binary mode sends only dibits 00 and 11
// - rotation counterclockwise; both top config bits set reverse it
// - scrambler is 7-bit self-synchronizing register, taps from config
// - descrambler uses the same tap polynomial as the scrambler
// - all bits scrambled when enabled; a control bit disables it
// - output is data xor parity of tapped quotient bits held in register
// - seed loadable from seed register; optional, flush resyncs
// - header and preamble binary, data quaternary, switched automatically
// - clear indicator pin in real time from ed, ecs or both ored
// - energy detect is rssi above threshold; all ones disables it
// - with power enable low, energy detect still tracks channel
// - with power enable high, energy detect refreshes every microsecond
// - early sense is quality above threshold, at dwell end then per 64/128
// - early sense part valid 17.1 us after power enable rises
// - indicator never touches tx or rx; polarity from bit 5
// - acquisition and data threshold pairs; acquisition pair feeds ecs
// - differential demod during initial acquisition, coherent afterwards
// - phase errors drive nco via lead/lag filter; variance is quality
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module dsc_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TX_BIT_VALID,
  input wire logic TX_BIT,
  input wire logic TX_IN_HEADER,
  output logic TX_PHASE_VALID,
  output logic [1:0] TX_PHASE,
  input wire logic RX_BIT_VALID,
  input wire logic RX_BIT,
  output logic RX_DATA_VALID,
  output logic RX_DATA,
  input wire logic [5:0] RSSI,
  input wire logic RX_POWER_ENABLE,
  input wire logic [15:0] CORRELATION_QUALITY,
  input wire logic DWELL_END,
  input wire logic SYMBOL_STROBE,
  input wire logic RX_DATA_READY,
  input wire logic ACQ_DONE,
  input wire logic PHASE_ERR_VALID,
  input wire logic [7:0] PHASE_ERR,
  output logic CHANNEL_CLEAR_INDICATOR,
  output logic CARRIER_SENSE_ACQ,
  output logic COHERENT,
  output logic [15:0] NCO_CTRL,
  output logic [15:0] SIGNAL_QUALITY
);
  logic rst_s1, rst_s2, rst_n;
  dsc_pkg::dsc_state_t q, n;
  logic acc_en, hit, wr, scr_en, rev, bpsk;
  logic tfb, sb, rfb, ed_raw, ecs_raw, busy;
  logic [5:0] idx;
  logic [1:0] step;
  logic [7:0] lim;
  logic [15:0] ecs_thr, crs_thr;
  logic signed [15:0] sq, serr;

  // reset released through two flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n = rst_s2;

  assign idx = PADDR[7:2];
  assign acc_en = PSEL & PENABLE;
  assign hit = acc_en & q.rdy;
  assign wr = hit & PWRITE & ~q.err;
  assign scr_en = q.ctl[dsc_pkg::CTL_SCR];
  assign rev = q.tap[dsc_pkg::ROT_BIT] & q.rot[dsc_pkg::ROT_BIT];
  assign bpsk = TX_IN_HEADER | ~q.ctl[dsc_pkg::CTL_QPSK];
  assign tfb = ^(q.tsr & q.tap[6:0]);
  assign sb = scr_en ? (TX_BIT ^ tfb) : TX_BIT;
  assign rfb = ^(q.rsr & q.tap[6:0]);
  assign ed_raw = (q.edt != dsc_pkg::ED_OFF) && (q.rs2 > q.edt);
  // acquisition pair also sets ecs threshold
  assign ecs_thr = {q.aqh, q.aql};
  assign crs_thr = RX_DATA_READY ? {q.dth, q.dtl} : ecs_thr;
  assign ecs_raw = CORRELATION_QUALITY > ecs_thr;
  assign lim = q.ctl[dsc_pkg::CTL_128] ? dsc_pkg::ECS_LONG : dsc_pkg::ECS_SHORT;
  assign busy = (q.ctl[dsc_pkg::CTL_ED] & q.ed)
    | (q.ctl[dsc_pkg::CTL_ECS] & q.ecs & q.ecsok);
  assign serr = {{8{PHASE_ERR[7]}}, PHASE_ERR};
  assign sq = serr * serr;

  always_comb begin
    n = q;
    step = 2'b00;
    // apb: one wait state, answer on second access cycle
    n.rdy = acc_en & ~q.rdy;
    // error flag stands only with the answer, so the pin needs no gate
    n.err = 1'b0;
    if (acc_en & ~q.rdy) begin
      n.prd = 32'h0;
      case (idx)
        dsc_pkg::IDX_ROT: n.prd[7:0] = q.rot;
        dsc_pkg::IDX_POL: n.prd[7:0] = q.pol;
        dsc_pkg::IDX_SEED: n.prd[7:0] = q.seed;
        dsc_pkg::IDX_TAP: n.prd[7:0] = q.tap;
        dsc_pkg::IDX_ED: n.prd[5:0] = q.edt;
        dsc_pkg::IDX_AQH: n.prd[7:0] = q.aqh;
        dsc_pkg::IDX_AQL: n.prd[7:0] = q.aql;
        dsc_pkg::IDX_DTH: n.prd[7:0] = q.dth;
        dsc_pkg::IDX_DTL: n.prd[7:0] = q.dtl;
        dsc_pkg::IDX_CTL: n.prd[7:0] = q.ctl;
        dsc_pkg::IDX_STA: n.prd = {q.qual, 8'h00, 2'b00, q.carrier_sense_acq, q.st == dsc_pkg::DM_COH,
          q.cci, q.ecsok, q.ecs, q.ed};
        default: n.err = 1'b1;
      endcase
    end
    if (wr) begin
      case (idx)
        dsc_pkg::IDX_ROT: n.rot = PWDATA[7:0];
        dsc_pkg::IDX_POL: n.pol = PWDATA[7:0];
        dsc_pkg::IDX_SEED: n.seed = PWDATA[7:0];
        dsc_pkg::IDX_TAP: n.tap = PWDATA[7:0];
        dsc_pkg::IDX_ED: n.edt = PWDATA[5:0];
        dsc_pkg::IDX_AQH: n.aqh = PWDATA[7:0];
        dsc_pkg::IDX_AQL: n.aql = PWDATA[7:0];
        dsc_pkg::IDX_DTH: n.dth = PWDATA[7:0];
        dsc_pkg::IDX_DTL: n.dtl = PWDATA[7:0];
        dsc_pkg::IDX_CTL: begin
          n.ctl = PWDATA[7:0];
          n.ctl[dsc_pkg::CTL_SEED] = 1'b0;
        end
        default: n.err = 1'b0;
      endcase
    end
    // transmit scrambler and encoder
    n.tvld = 1'b0;
    if (TX_BIT_VALID) begin
      if (scr_en) begin
        n.tsr = {q.tsr[5:0], sb};
      end
      if (bpsk) begin
        step = {sb, sb};
        n.tvld = 1'b1;
        n.half = 1'b0;
      end else if (!q.half) begin
        n.hbit = sb;
        n.half = 1'b1;
      end else begin
        step = {q.hbit, sb};
        n.tvld = 1'b1;
        n.half = 1'b0;
      end
    end
    if (n.tvld) begin
      case (step)
        2'b00: step = 2'b00;
        2'b01: step = 2'b01;
        2'b11: step = 2'b10;
        2'b10: step = 2'b11;
        default: step = 2'b00;
      endcase
      if (rev) begin
        step = -step;
      end
      n.tph = q.tph + step;
    end
    // optional seed load, wins over a shift
    if (wr && idx == dsc_pkg::IDX_CTL && PWDATA[dsc_pkg::CTL_SEED]) begin
      n.tsr = q.seed[6:0];
      n.half = 1'b0;
    end
    // receive descrambler
    n.rvld = RX_BIT_VALID;
    if (RX_BIT_VALID) begin
      n.rbit = scr_en ? (RX_BIT ^ rfb) : RX_BIT;
      n.rsr = {q.rsr[5:0], RX_BIT};
    end
    // pin synchronisers
    n.rs1 = RSSI;
    n.rs2 = q.rs1;
    n.pe1 = RX_POWER_ENABLE;
    n.pe2 = q.pe1;
    if (!q.pe2) begin
      // energy tracked with power enable low
      n.ed = ed_raw;
      n.edcnt = 5'h00;
      n.vcnt = 9'h000;
      n.ecsok = 1'b0;
      n.ecs = 1'b0;
      n.arm = 1'b0;
      n.scnt = 8'h00;
      n.st = dsc_pkg::DM_DIFF;
    end else begin
      if (q.edcnt == dsc_pkg::ED_LAST) begin
        n.ed = ed_raw;
        n.edcnt = 5'h00;
      end else begin
        n.edcnt = q.edcnt + 5'h01;
      end
      // early sense blanked until valid time
      if (q.vcnt == dsc_pkg::ECS_LAST) begin
        n.ecsok = 1'b1;
      end else begin
        n.vcnt = q.vcnt + 9'h001;
      end
      // dwell end, then every 64 or 128 symbols
      if (DWELL_END) begin
        n.ecs = ecs_raw;
        n.arm = 1'b1;
        n.scnt = 8'h00;
      end else if (q.arm && SYMBOL_STROBE) begin
        if (q.scnt == lim - 8'h01) begin
          n.ecs = ecs_raw;
          n.scnt = 8'h00;
        end else begin
          n.scnt = q.scnt + 8'h01;
        end
      end
      case (q.st)
        dsc_pkg::DM_DIFF: if (ACQ_DONE) n.st = dsc_pkg::DM_COH;
        dsc_pkg::DM_COH: n.st = dsc_pkg::DM_COH;
        default: n.st = dsc_pkg::DM_DIFF;
      endcase
    end
    n.cci = ~busy ^ q.pol[dsc_pkg::POL_BIT];
    // acquisition or data pair for carrier sense
    n.carrier_sense_acq = q.pe2 & (CORRELATION_QUALITY > crs_thr);
    if (PHASE_ERR_VALID) begin
      if (q.st == dsc_pkg::DM_COH) begin
        n.integ = q.integ + serr;
        n.nco = n.integ + (serr <<< 2);
      end
      n.acc = q.acc + {4'h0, sq};
      n.qcnt = q.qcnt + 4'h1;
      if (q.qcnt == 4'hf) begin
        n.qual = n.acc[19:4];
        n.acc = 20'h00000;
      end
    end
    if (q.st == dsc_pkg::DM_DIFF) begin
      n.integ = 16'h0000;
      n.nco = 16'h0000;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.tap <= dsc_pkg::TAP_RST;
      q.ctl <= dsc_pkg::CTL_RST;
      q.edt <= dsc_pkg::ED_RST;
      q.st <= dsc_pkg::DM_DIFF;
      q.cci <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign PRDATA = q.prd;
  assign PREADY = q.rdy;
  assign PSLVERR = q.err;
  assign TX_PHASE_VALID = q.tvld;
  assign TX_PHASE = q.tph;
  assign RX_DATA_VALID = q.rvld;
  assign RX_DATA = q.rbit;
  assign CHANNEL_CLEAR_INDICATOR = q.cci;
  assign CARRIER_SENSE_ACQ = q.carrier_sense_acq;
  // one-hot state, so the coherent bit is a flop of its own
  assign COHERENT = q.st[1];
  assign NCO_CTRL = q.nco;
  assign SIGNAL_QUALITY = q.qual;

  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_q01;
    TX_BIT_VALID && !bpsk && q.half && !q.hbit && sb;
  endsequence
  sequence s_pe_up;
    !q.pe2 ##1 q.pe2;
  endsequence

  a_dibit_plus90: assert property (s_q01 and !rev |=> q.tph == $past(q.tph) + 2'd1)
    else $error("dibit 01 not +90");
  a_bin_halfturn: assert property (TX_BIT_VALID && bpsk && sb
    |=> q.tvld && q.tph == $past(q.tph) + 2'd2)
    else $error("binary one not half turn");
  a_rot_reverse: assert property (s_q01 and rev |=> q.tph == $past(q.tph) + 2'd3)
    else $error("reversed rotation wrong");
  a_scr_feedback: assert property (TX_BIT_VALID && scr_en && !wr
    |=> q.tsr[0] == ($past(TX_BIT) ^ ^($past(q.tsr) & $past(q.tap[6:0]))))
    else $error("scrambler bit wrong");
  a_scr_bypass: assert property (TX_BIT_VALID && !scr_en && !wr |=> $stable(q.tsr))
    else $error("scrambler moved while off");
  a_descr_shift: assert property (RX_BIT_VALID |=> q.rsr[0] == $past(RX_BIT)
    && RX_DATA_VALID)
    else $error("descrambler input not shifted");
  a_ed_off: assert property (q.edt == dsc_pkg::ED_OFF && !q.pe2 |=> !q.ed)
    else $error("energy detect not disabled");
  a_ed_hold: assert property (q.pe2 && $past(q.pe2) && q.edcnt != dsc_pkg::ED_LAST
    |=> $stable(q.ed))
    else $error("energy detect changed early");
  a_ecs_blank: assert property (s_pe_up |-> !q.ecsok [*8])
    else $error("early sense valid too soon");
  a_cci_follow: assert property (##1 q.cci == (~$past(busy) ^ $past(q.pol[5])))
    else $error("indicator mismatch");
  a_coh_entry: assert property ($rose(COHERENT) |-> $past(ACQ_DONE))
    else $error("coherent without acquisition");
  a_apb_ready: assert property (acc_en && !q.rdy |=> q.rdy ##1 !q.rdy)
    else $error("apb answer timing");

  sequence s_qpsk_first;
    TX_BIT_VALID && !bpsk && !q.half && !wr;
  endsequence

  a_qpsk_pair: assert property (s_qpsk_first |=> q.half && !q.tvld)
    else $error("first quaternary bit not held");
  a_seed_load: assert property (wr && idx == dsc_pkg::IDX_CTL && PWDATA[dsc_pkg::CTL_SEED]
    |=> q.tsr == $past(q.seed[6:0]) && !q.half)
    else $error("seed not loaded");
  a_cci_or: assert property (q.ctl[dsc_pkg::CTL_ED] && q.ed && !q.pol[dsc_pkg::POL_BIT]
    |=> !q.cci)
    else $error("energy busy not shown");
  a_ecs_dwell: assert property (q.pe2 && DWELL_END
    |=> q.ecs == $past(CORRELATION_QUALITY > {q.aqh, q.aql}))
    else $error("early sense not taken at dwell end");
  a_ecs_hold: assert property (q.pe2 && !DWELL_END && !(q.arm && SYMBOL_STROBE)
    |=> $stable(q.ecs))
    else $error("early sense changed between updates");
  a_ecs_long: assert property (q.pe2 && q.arm && SYMBOL_STROBE && !DWELL_END
    && q.ctl[dsc_pkg::CTL_128] && q.scnt == 8'h3f |=> $stable(q.ecs))
    else $error("early sense updated at 64 in long mode");
  a_crs_off: assert property (!q.pe2 |=> !q.carrier_sense_acq)
    else $error("carrier sense with power off");
  a_nco_idle: assert property (q.st == dsc_pkg::DM_DIFF |=> q.nco == 16'h0000)
    else $error("nco moved in differential state");
  a_qual_wrap: assert property (PHASE_ERR_VALID && q.qcnt == 4'hf
    |=> q.qcnt == 4'h0 && q.acc == 20'h00000)
    else $error("quality block not closed");
endmodule // dsc_top

// ==== pkg/dsc_pkg.sv ====
// package: constants, state layout and types of the dsss coder block
package dsc_pkg;
  // timing
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned ED_PERIOD_NS = 1000;
  localparam int unsigned ED_CYC = ED_PERIOD_NS / CLK_NS;
  localparam int unsigned ECS_VALID_NS = 17100;
  localparam int unsigned ECS_CYC = (ECS_VALID_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] ED_LAST = 5'(ED_CYC - 1);
  localparam logic [8:0] ECS_LAST = 9'(ECS_CYC - 1);
  localparam logic [7:0] ECS_SHORT = 8'h40;
  localparam logic [7:0] ECS_LONG = 8'h80;
  // register indices, byte address is index times four
  localparam logic [5:0] IDX_ROT = 6'h05;
  localparam logic [5:0] IDX_POL = 6'h09;
  localparam logic [5:0] IDX_SEED = 6'h0f;
  localparam logic [5:0] IDX_TAP = 6'h10;
  localparam logic [5:0] IDX_ED = 6'h13;
  localparam logic [5:0] IDX_AQH = 6'h16;
  localparam logic [5:0] IDX_AQL = 6'h17;
  localparam logic [5:0] IDX_DTH = 6'h1a;
  localparam logic [5:0] IDX_DTL = 6'h1b;
  localparam logic [5:0] IDX_CTL = 6'h3c;
  localparam logic [5:0] IDX_STA = 6'h3d;
  // field positions
  localparam int unsigned CTL_SCR = 0;
  localparam int unsigned CTL_QPSK = 1;
  localparam int unsigned CTL_SEED = 2;
  localparam int unsigned CTL_ED = 3;
  localparam int unsigned CTL_ECS = 4;
  localparam int unsigned CTL_128 = 5;
  localparam int unsigned ROT_BIT = 7;
  localparam int unsigned POL_BIT = 5;
  // reset values
  localparam logic [7:0] TAP_RST = 8'h48;
  localparam logic [7:0] CTL_RST = 8'h19;
  localparam logic [5:0] ED_RST = 6'h20;
  localparam logic [5:0] ED_OFF = 6'h3f;
  typedef enum logic [1:0] {
    DM_DIFF = 2'b01,
    DM_COH = 2'b10
  } dsc_dm_t;
  typedef struct packed {
    logic rdy; logic err; logic [31:0] prd;
    logic [7:0] rot, pol, seed, tap, ctl, aqh, aql, dth, dtl;
    logic [5:0] edt;
    logic [6:0] tsr; logic half; logic hbit;
    logic tvld; logic [1:0] tph;
    logic [6:0] rsr; logic rvld; logic rbit;
    logic [5:0] rs1, rs2; logic pe1, pe2;
    logic ed; logic [4:0] edcnt;
    logic ecs; logic arm; logic [7:0] scnt;
    logic [8:0] vcnt; logic ecsok;
    logic cci; logic carrier_sense_acq;
    dsc_dm_t st; logic [15:0] integ, nco;
    logic [19:0] acc; logic [3:0] qcnt; logic [15:0] qual;
  } dsc_state_t;
endpackage

// ==== test/dsc_mac_model.sv ====
// mac controller model that watches the channel indicator
`timescale 1ns/1ns
module dsc_mac_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear_lvl,
  input wire logic ind,
  input wire logic pwr_en,
  input wire logic rdy,
  input wire logic dwell,
  output logic busy
);
  logic [6:0] hold_r;
  logic [1:0] run_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 7'h00;
      run_r <= 2'h0;
      busy <= 1'b0;
    end else if (!pwr_en) begin
      hold_r <= 7'h00;
      run_r <= 2'h0;
      busy <= 1'b0;
    end else if (hold_r != 7'h64) begin
      hold_r <= hold_r + 7'h01;
    end else if (!rdy && dwell) begin
      if (ind == clear_lvl) begin
        run_r <= 2'h0;
        busy <= 1'b0;
      end else if (run_r == 2'h2) begin
        busy <= 1'b1;
      end else begin
        run_r <= run_r + 2'h1;
      end
    end
  end
endmodule // dsc_mac_model

// ==== test/dsc_top_tb.sv ====
// self-checking bench of the dsss coder block
`timescale 1ns/1ns
module dsc_top_tb;
  logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e, mac_busy;
  logic [7:0] PADDR, PHASE_ERR;
  logic [31:0] PWDATA, PRDATA, q;
  logic TX_BIT_VALID, TX_BIT, TX_IN_HEADER, TX_PHASE_VALID, RX_BIT_VALID, RX_BIT;
  logic RX_DATA_VALID, RX_DATA, RX_POWER_ENABLE, DWELL_END, SYMBOL_STROBE, RX_DATA_READY;
  logic ACQ_DONE, PHASE_ERR_VALID, CHANNEL_CLEAR_INDICATOR, CARRIER_SENSE_ACQ, COHERENT;
  logic [1:0] TX_PHASE, p;
  logic [5:0] RSSI;
  logic [15:0] CORRELATION_QUALITY, NCO_CTRL, SIGNAL_QUALITY;
  int bad_count, n_compared, cycles;
  localparam logic [1:0] DB [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h1};
  localparam logic [1:0] ST [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  dsc_top DUT (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .TX_BIT_VALID, .TX_BIT, .TX_IN_HEADER, .TX_PHASE_VALID, .TX_PHASE,
    .RX_BIT_VALID, .RX_BIT, .RX_DATA_VALID, .RX_DATA, .RSSI, .RX_POWER_ENABLE,
    .CORRELATION_QUALITY, .DWELL_END, .SYMBOL_STROBE, .RX_DATA_READY, .ACQ_DONE,
    .PHASE_ERR_VALID, .PHASE_ERR, .CHANNEL_CLEAR_INDICATOR, .CARRIER_SENSE_ACQ, .COHERENT,
    .NCO_CTRL, .SIGNAL_QUALITY);
  dsc_mac_model MAC (.clk(CLK), .rst_n(ARST_N), .clear_lvl(1'b1),
    .ind(CHANNEL_CLEAR_INDICATOR), .pwr_en(RX_POWER_ENABLE), .rdy(RX_DATA_READY),
    .dwell(DWELL_END), .busy(mac_busy));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task complete_run;
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // whole run needs about 2000 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // pready read once settled; the next edge completes the transfer
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    chk(PREADY, 1'b1);
    q = PRDATA;
    e = PSLVERR;
    @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, 1'b0);
  endtask
  task automatic tx(input logic b);
    @(posedge CLK);
    TX_BIT_VALID <= 1'b1;
    TX_BIT <= b;
    @(posedge CLK);
    TX_BIT_VALID <= 1'b0;
    #1;
  endtask
  task automatic rx(input logic b);
    @(posedge CLK);
    RX_BIT_VALID <= 1'b1;
    RX_BIT <= b;
    @(posedge CLK);
    RX_BIT_VALID <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic dw);
    @(posedge CLK);
    if (dw) DWELL_END <= 1'b1;
    else SYMBOL_STROBE <= 1'b1;
    @(posedge CLK);
    DWELL_END <= 1'b0;
    SYMBOL_STROBE <= 1'b0;
    cyc(4);
  endtask
  task t_regs;
    rdc(8'h40, 32'h48);
    rdc(8'hf0, 32'h19);
    rdc(8'h4c, 32'h20);
    apb(1'b1, 8'h80, 32'hff);
    chk(e, 1'b1);
  endtask
  task t_tx;
    wr(8'hf0, 32'h0a);
    TX_IN_HEADER <= 1'b1;
    p = 2'h0;
    for (int i = 0; i < 4; i++) begin
      tx(i[0]);
      p = p + {i[0], 1'b0};
      chk({TX_PHASE_VALID, TX_PHASE}, {1'b1, p});
    end
    @(posedge CLK);
    TX_IN_HEADER <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        wr(8'h40, 32'hc8);
        wr(8'h14, 32'h80);
      end
      tx(DB[i][1]);
      chk(TX_PHASE_VALID, 1'b0);
      tx(DB[i][0]);
      p = p + ST[i];
      chk({TX_PHASE_VALID, TX_PHASE}, {1'b1, p});
    end
    wr(8'h40, 32'h48);
    wr(8'h14, 32'h00);
  endtask
  task t_loop;
    logic [31:0] pat;
    logic s;
    int diff;
    pat = 32'h0f35_ffff;
    diff = 0;
    wr(8'hf0, 32'h09);
    TX_IN_HEADER <= 1'b1;
    p = TX_PHASE;
    for (int i = 0; i < 32; i++) begin
      tx(pat[i]);
      s = TX_PHASE[1] ^ p[1];
      chk(TX_PHASE[0] ^ p[0], 1'b0);
      p = TX_PHASE;
      diff += int'(s != pat[i]);
      rx(s);
      if (i > 6) chk({RX_DATA_VALID, RX_DATA}, {1'b1, pat[i]});
    end
    chk(diff != 0, 1'b1);
    wr(8'h3c, 32'h55);
    rdc(8'h3c, 32'h55);
    wr(8'hf0, 32'h0d);
    rdc(8'hf0, 32'h09);
    p = TX_PHASE;
    tx(1'b0);
    // loaded seed decides the first scrambled bit
    p = p + {^(7'h55 & 7'h48), 1'b0};
    chk(TX_PHASE, p);
  endtask
  task t_ed;
    int n;
    wr(8'hf0, 32'h09);
    RSSI <= 6'h21;
    cyc(6);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b0);
    RSSI <= 6'h20;
    cyc(6);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b1);
    wr(8'h24, 32'h20);
    cyc(3);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b0);
    wr(8'h24, 32'h00);
    wr(8'h4c, 32'h3f);
    RSSI <= 6'h3f;
    cyc(6);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b1);
    wr(8'h4c, 32'h20);
    RSSI <= 6'h00;
    RX_POWER_ENABLE <= 1'b1;
    cyc(30);
    RSSI <= 6'h3f;
    n = 0;
    while (CHANNEL_CLEAR_INDICATOR !== 1'b0 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(n > 6 && n < 27, 1'b1);
  endtask
  task t_ecs;
    wr(8'hf0, 32'h11);
    wr(8'h58, 32'h01);
    wr(8'h5c, 32'h00);
    RSSI <= 6'h00;
    CORRELATION_QUALITY <= 16'h0200;
    RX_POWER_ENABLE <= 1'b0;
    cyc(5);
    RX_POWER_ENABLE <= 1'b1;
    cyc(100);
    pulse(1'b1);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b1);
    cyc(250);
    for (int i = 0; i < 4; i++) pulse(1'b1);
    chk({mac_busy, CHANNEL_CLEAR_INDICATOR}, 2'b10);
    CORRELATION_QUALITY <= 16'h0000;
    repeat (63) pulse(1'b0);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b0);
    pulse(1'b0);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b1);
    wr(8'h68, 32'h03);
    wr(8'h6c, 32'h00);
    CORRELATION_QUALITY <= 16'h0200;
    cyc(2);
    chk(CARRIER_SENSE_ACQ, 1'b1);
    RX_DATA_READY <= 1'b1;
    cyc(2);
    chk(CARRIER_SENSE_ACQ, 1'b0);
    RX_DATA_READY <= 1'b0;
    wr(8'hf0, 32'h31);
    pulse(1'b1);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b0);
    CORRELATION_QUALITY <= 16'h0000;
    repeat (127) pulse(1'b0);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b0);
    pulse(1'b0);
    chk(CHANNEL_CLEAR_INDICATOR, 1'b1);
  endtask
  task t_demod;
    chk(COHERENT, 1'b0);
    ACQ_DONE <= 1'b1;
    cyc(1);
    ACQ_DONE <= 1'b0;
    cyc(3);
    chk(COHERENT, 1'b1);
    PHASE_ERR <= 8'h04;
    PHASE_ERR_VALID <= 1'b1;
    cyc(16);
    PHASE_ERR_VALID <= 1'b0;
    cyc(4);
    chk(SIGNAL_QUALITY, 16'h0010);
    chk(NCO_CTRL != 16'h0000, 1'b1);
    RX_POWER_ENABLE <= 1'b0;
    cyc(5);
    chk(COHERENT, 1'b0);
  endtask
  initial begin
    {ARST_N, PSEL, PENABLE, PWRITE, TX_BIT_VALID, TX_BIT, TX_IN_HEADER, RX_BIT} = '0;
    {RX_BIT_VALID, RX_POWER_ENABLE, DWELL_END, SYMBOL_STROBE, RX_DATA_READY} = '0;
    {ACQ_DONE, PHASE_ERR_VALID, PADDR, PHASE_ERR, PWDATA, RSSI, CORRELATION_QUALITY} = '0;
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    cyc(3);
    t_regs;
    t_tx;
    t_loop;
    t_ed;
    t_ecs;
    t_demod;
    complete_run;
  end
endmodule // dsc_top_tb
